// >>> tap_controller_port.sv
// Four-pin test access port: controller, instruction register, ID and
// bypass registers, four scan chains and the crossing to the system clock.
// Assumes i_tck is free of i_clk; fuse and disable bit are i_clk levels.
//
// Summary of operation
// - Sixteen-state controller stepped by TMS at each rising TCK edge.
// - Power-on reset puts the controller in Test-Logic-Reset.
// - All shift registers shift least significant bit first, in and out.
// - Capture-IR loads 0x01, which shifts out on TDO.
// - Instruction latches only in Update-IR; TMS 1,1,0 returns to Idle.
// - Latched instruction picks the data register between TDI and TDO.
// - TMS low except last bit; captured parallel values shift out.
// - Latched data register outputs change only in Update-DR.
// - Five TCK periods of TMS high reach Test-Logic-Reset from anywhere.
// - No test reset pin; reset from power-on, TMS, or disable.
// - Fuse unprogrammed: pins are ordinary pins, controller held reset.
// - Fuse programmed, disable clear: pull-ups on, port enabled.
// - TDO undriven outside the shifting states.
// - Registers: ID, bypass, boundary, programming, internal, breakpoint.
// - Idle is optional between scans and may run instruction actions.
// - Exit, pause and exit-2 states do nothing but navigate.
`timescale 1ns/1ps
`include "tap_port_consts.svh"

module tap_controller_port #(
	parameter int BS_W = `TAP_BS_W_DEF,
	parameter int PROG_W = `TAP_PROG_W_DEF,
	parameter int ISC_W = `TAP_ISC_W_DEF,
	parameter int BPC_W = `TAP_BPC_W_DEF,
	parameter logic [`TAP_ID_W-1:0] ID_VALUE = `TAP_ID_VALUE_DEF,
	parameter int TOT_W = BS_W + PROG_W + ISC_W + BPC_W
) (
	input wire logic i_clk,
	input wire logic i_srst,
	input wire logic i_ce,
	input wire logic i_test_port_enable_fuse,
	input wire logic i_test_port_disable_bit,
	input wire logic i_tck,
	input wire logic i_tms,
	input wire logic i_tdi,
	input wire logic [TOT_W-1:0] i_chain_cap,
	output logic o_tdo,
	output logic o_tdo_oe,
	output logic o_pullup_en,
	output logic o_gpio_mode,
	output logic [`TAP_IR_W-1:0] o_instr,
	output logic [TOT_W-1:0] o_chain_upd,
	output logic o_update_stb,
	output logic o_run_idle,
	output logic o_tap_reset
);
	// Chain offsets inside the packed capture and update vectors
	localparam int BS_LO = 0;
	localparam int PROG_LO = BS_W;
	localparam int ISC_LO = BS_W + PROG_W;
	localparam int BPC_LO = BS_W + PROG_W + ISC_W;

	// System clock domain record
	typedef struct packed {
		logic hold;
		logic pull;
		logic gpio;
		logic [2:0] tgl_s;
		logic tgl_seen;
		logic [2:0] idle_s;
		logic [2:0] rst_s;
		logic [`TAP_IR_W-1:0] instr;
		logic [TOT_W-1:0] upd;
		logic stb;
		logic run_idle;
		logic tap_reset;
	} clk_state_t;

	tap_port_pkg::tck_rise_t rq;
	tap_port_pkg::tck_rise_t rd;
	tap_port_pkg::tck_fall_t fq;
	tap_port_pkg::tck_fall_t fd;
	clk_state_t cq;
	clk_state_t cd;
	tap_port_pkg::dr_sel_t sel;
	logic t_rst;
	logic t_run;
	logic [3:0] chain_sout;
	logic [TOT_W-1:0] chain_par;

	if (BS_W < 1 || PROG_W < 1 || ISC_W < 1 || BPC_W < 1) begin : g_bad_w
		$error("tap_controller_port chain widths must be at least one");
	end
	if (TOT_W != BS_W + PROG_W + ISC_W + BPC_W) begin : g_bad_tot
		$error("tap_controller_port TOT_W must be the sum of chain widths");
	end

	// Next controller state from the current state and sampled TMS
	function automatic tap_port_pkg::tap_state_t tap_next(
		input tap_port_pkg::tap_state_t s,
		input logic tms
	);
		tap_port_pkg::tap_state_t n;
		n = tap_port_pkg::ST_RESET;
		case (s)
			tap_port_pkg::ST_RESET: begin
				n = tms ? tap_port_pkg::ST_RESET : tap_port_pkg::ST_IDLE;
			end
			tap_port_pkg::ST_IDLE: begin
				n = tms ? tap_port_pkg::ST_SEL_DR : tap_port_pkg::ST_IDLE;
			end
			tap_port_pkg::ST_SEL_DR: begin
				n = tms ? tap_port_pkg::ST_SEL_IR : tap_port_pkg::ST_CAP_DR;
			end
			tap_port_pkg::ST_CAP_DR: begin
				n = tms ? tap_port_pkg::ST_EX1_DR : tap_port_pkg::ST_SH_DR;
			end
			tap_port_pkg::ST_SH_DR: begin
				n = tms ? tap_port_pkg::ST_EX1_DR : tap_port_pkg::ST_SH_DR;
			end
			tap_port_pkg::ST_EX1_DR: begin
				n = tms ? tap_port_pkg::ST_UPD_DR : tap_port_pkg::ST_PAU_DR;
			end
			tap_port_pkg::ST_PAU_DR: begin
				n = tms ? tap_port_pkg::ST_EX2_DR : tap_port_pkg::ST_PAU_DR;
			end
			tap_port_pkg::ST_EX2_DR: begin
				n = tms ? tap_port_pkg::ST_UPD_DR : tap_port_pkg::ST_SH_DR;
			end
			tap_port_pkg::ST_UPD_DR: begin
				n = tms ? tap_port_pkg::ST_SEL_DR : tap_port_pkg::ST_IDLE;
			end
			tap_port_pkg::ST_SEL_IR: begin
				n = tms ? tap_port_pkg::ST_RESET : tap_port_pkg::ST_CAP_IR;
			end
			tap_port_pkg::ST_CAP_IR: begin
				n = tms ? tap_port_pkg::ST_EX1_IR : tap_port_pkg::ST_SH_IR;
			end
			tap_port_pkg::ST_SH_IR: begin
				n = tms ? tap_port_pkg::ST_EX1_IR : tap_port_pkg::ST_SH_IR;
			end
			tap_port_pkg::ST_EX1_IR: begin
				n = tms ? tap_port_pkg::ST_UPD_IR : tap_port_pkg::ST_PAU_IR;
			end
			tap_port_pkg::ST_PAU_IR: begin
				n = tms ? tap_port_pkg::ST_EX2_IR : tap_port_pkg::ST_PAU_IR;
			end
			tap_port_pkg::ST_EX2_IR: begin
				n = tms ? tap_port_pkg::ST_UPD_IR : tap_port_pkg::ST_SH_IR;
			end
			tap_port_pkg::ST_UPD_IR: begin
				n = tms ? tap_port_pkg::ST_SEL_DR : tap_port_pkg::ST_IDLE;
			end
			default: begin
				n = tap_port_pkg::ST_RESET;
			end
		endcase
		return n;
	endfunction

	// Instruction decode; unknown opcodes fall back to bypass
	function automatic tap_port_pkg::dr_sel_t decode(
		input logic [`TAP_IR_W-1:0] op
	);
		tap_port_pkg::dr_sel_t s;
		s = tap_port_pkg::SEL_BYPASS;
		case (op)
			`TAP_OP_IDCODE: s = tap_port_pkg::SEL_ID;
			`TAP_OP_EXTEST: s = tap_port_pkg::SEL_BOUNDARY;
			`TAP_OP_SAMPLE: s = tap_port_pkg::SEL_BOUNDARY;
			`TAP_OP_PROG: s = tap_port_pkg::SEL_PROG;
			`TAP_OP_ISCAN0: s = tap_port_pkg::SEL_INTSCAN;
			`TAP_OP_ISCAN1: s = tap_port_pkg::SEL_INTSCAN;
			`TAP_OP_BREAK0: s = tap_port_pkg::SEL_BREAK;
			`TAP_OP_BREAK1: s = tap_port_pkg::SEL_BREAK;
			`TAP_OP_BYPASS: s = tap_port_pkg::SEL_BYPASS;
			default: s = tap_port_pkg::SEL_BYPASS;
		endcase
		return s;
	endfunction

	// Reset and clock enable seen in the test clock domain
	assign t_rst = rq.rst_sync[1];
	assign t_run = rq.ce_sync[1];
	assign sel = decode(rq.ir);

	// Control bundle for the scan chains
	scan_ctrl_if sbus (.tck(i_tck));
	assign sbus.rst = t_rst;
	assign sbus.run = t_run;
	assign sbus.capture = (rq.state == tap_port_pkg::ST_CAP_DR);
	assign sbus.shift = (rq.state == tap_port_pkg::ST_SH_DR);
	assign sbus.update = (rq.state == tap_port_pkg::ST_UPD_DR);
	assign sbus.tdi = i_tdi;

	// Boundary, programming, internal and breakpoint chains
	scan_data_reg #(.W(BS_W)) u_boundary (
		.bus(sbus),
		.i_sel(sel == tap_port_pkg::SEL_BOUNDARY),
		.i_cap(i_chain_cap[BS_LO +: BS_W]),
		.o_sout(chain_sout[0]),
		.o_par(chain_par[BS_LO +: BS_W])
	);
	scan_data_reg #(.W(PROG_W)) u_prog (
		.bus(sbus),
		.i_sel(sel == tap_port_pkg::SEL_PROG),
		.i_cap(i_chain_cap[PROG_LO +: PROG_W]),
		.o_sout(chain_sout[1]),
		.o_par(chain_par[PROG_LO +: PROG_W])
	);
	scan_data_reg #(.W(ISC_W)) u_intscan (
		.bus(sbus),
		.i_sel(sel == tap_port_pkg::SEL_INTSCAN),
		.i_cap(i_chain_cap[ISC_LO +: ISC_W]),
		.o_sout(chain_sout[2]),
		.o_par(chain_par[ISC_LO +: ISC_W])
	);
	scan_data_reg #(.W(BPC_W)) u_break (
		.bus(sbus),
		.i_sel(sel == tap_port_pkg::SEL_BREAK),
		.i_cap(i_chain_cap[BPC_LO +: BPC_W]),
		.o_sout(chain_sout[3]),
		.o_par(chain_par[BPC_LO +: BPC_W])
	);

	// Controller, instruction, ID and bypass registers on rising TCK
	always_comb begin
		rd = rq;
		rd.rst_sync = {rq.rst_sync[0], cq.hold};
		rd.ce_sync = {rq.ce_sync[0], i_ce};
		if (t_rst) begin
			rd.state = tap_port_pkg::ST_RESET;
			rd.ir = `TAP_OP_IDCODE;
			rd.ir_shift = '0;
			rd.id_shift = '0;
			rd.bypass = 1'b0;
			rd.upd_tgl = 1'b0; // Known toggle level once reset
		end else if (t_run) begin
			rd.state = tap_next(rq.state, i_tms);
			case (rq.state)
				tap_port_pkg::ST_CAP_IR: begin
					rd.ir_shift = `TAP_IR_CAPTURE;
				end
				tap_port_pkg::ST_SH_IR: begin
					rd.ir_shift = {i_tdi, rq.ir_shift[`TAP_IR_W-1:1]};
				end
				tap_port_pkg::ST_UPD_IR: begin
					rd.ir = rq.ir_shift;
				end
				tap_port_pkg::ST_CAP_DR: begin
					if (sel == tap_port_pkg::SEL_ID) begin
						rd.id_shift = ID_VALUE;
					end
					if (sel == tap_port_pkg::SEL_BYPASS) begin
						rd.bypass = 1'b0;
					end
				end
				tap_port_pkg::ST_SH_DR: begin
					if (sel == tap_port_pkg::SEL_ID) begin
						rd.id_shift = {i_tdi, rq.id_shift[`TAP_ID_W-1:1]};
					end
					if (sel == tap_port_pkg::SEL_BYPASS) begin
						rd.bypass = i_tdi;
					end
				end
				default: begin
					rd.state = rd.state;
				end
			endcase
			// Instruction holds IDCODE from the edge that enters reset
			if (rd.state == tap_port_pkg::ST_RESET) begin
				rd.ir = `TAP_OP_IDCODE;
			end
		end
		// Flag any new instruction or data update to the system side
		if (rd.ir != rq.ir || (!t_rst && t_run &&
				rq.state == tap_port_pkg::ST_UPD_DR)) begin
			rd.upd_tgl = ~rq.upd_tgl;
		end
		rd.at_idle = (rd.state == tap_port_pkg::ST_IDLE);
		rd.at_reset = (rd.state == tap_port_pkg::ST_RESET);
	end

	always_ff @(posedge i_tck) begin
		rq <= rd;
	end

	// Serial output on falling TCK, driven only while shifting
	always_comb begin
		fd = fq;
		if (t_rst) begin
			fd.tdo = 1'b0;
			fd.oe = 1'b0;
		end else if (t_run) begin
			fd.oe = 1'b0;
			fd.tdo = 1'b0;
			if (rq.state == tap_port_pkg::ST_SH_IR) begin
				fd.oe = 1'b1;
				fd.tdo = rq.ir_shift[0];
			end else if (rq.state == tap_port_pkg::ST_SH_DR) begin
				fd.oe = 1'b1;
				case (sel)
					tap_port_pkg::SEL_ID: fd.tdo = rq.id_shift[0];
					tap_port_pkg::SEL_BYPASS: fd.tdo = rq.bypass;
					tap_port_pkg::SEL_BOUNDARY: fd.tdo = chain_sout[0];
					tap_port_pkg::SEL_PROG: fd.tdo = chain_sout[1];
					tap_port_pkg::SEL_INTSCAN: fd.tdo = chain_sout[2];
					tap_port_pkg::SEL_BREAK: fd.tdo = chain_sout[3];
					default: fd.tdo = rq.bypass;
				endcase
			end
		end
	end

	always_ff @(negedge i_tck) begin
		fq <= fd;
	end

	// System side: enable decode, synchronisers and update capture
	always_comb begin
		cd = cq;
		if (i_srst) begin
			cd = '0;
			cd.hold = 1'b1;
			cd.gpio = 1'b1;
			cd.tap_reset = 1'b1;
			cd.instr = `TAP_OP_IDCODE;
		end else if (i_ce) begin
			cd.stb = 1'b0;
			cd.hold = ~(i_test_port_enable_fuse &
				~i_test_port_disable_bit);
			cd.pull = i_test_port_enable_fuse &
				~i_test_port_disable_bit;
			cd.gpio = ~(i_test_port_enable_fuse &
				~i_test_port_disable_bit);
			cd.tgl_s = {cq.tgl_s[1:0], rq.upd_tgl};
			cd.idle_s = {cq.idle_s[1:0], rq.at_idle};
			cd.rst_s = {cq.rst_s[1:0], rq.at_reset};
			if (cq.tgl_s[1] == cq.tgl_s[2] && cq.tgl_s[2] != cq.tgl_seen) begin
				cd.tgl_seen = cq.tgl_s[2];
				cd.instr = rq.ir;
				cd.upd = chain_par;
				cd.stb = 1'b1;
			end
			if (cq.idle_s[1] == cq.idle_s[2]) begin
				cd.run_idle = cq.idle_s[2];
			end
			if (cq.rst_s[1] == cq.rst_s[2]) begin
				cd.tap_reset = cq.rst_s[2];
			end
		end
	end

	always_ff @(posedge i_clk) begin
		cq <= cd;
	end

	// Outputs straight from registers
	assign o_tdo = fq.tdo;
	assign o_tdo_oe = fq.oe;
	assign o_pullup_en = cq.pull;
	assign o_gpio_mode = cq.gpio;
	assign o_instr = cq.instr;
	assign o_chain_upd = cq.upd;
	assign o_update_stb = cq.stb;
	assign o_run_idle = cq.run_idle;
	assign o_tap_reset = cq.tap_reset;
endmodule

// >>> tap_port_consts.svh
// Constants for the four-pin test access port: opcodes, capture values,
// default chain widths and reset values.
// Assumes inclusion by bare name from the package and the port module.
`ifndef TAP_PORT_CONSTS_SVH
`define TAP_PORT_CONSTS_SVH

// Instruction register width and value loaded in Capture-IR
`define TAP_IR_W 4
`define TAP_IR_CAPTURE 4'h1

// Instruction opcodes
`define TAP_OP_EXTEST 4'h0
`define TAP_OP_IDCODE 4'h1
`define TAP_OP_SAMPLE 4'h2
`define TAP_OP_PROG 4'h5
`define TAP_OP_ISCAN0 4'h8
`define TAP_OP_ISCAN1 4'h9
`define TAP_OP_BREAK0 4'hA
`define TAP_OP_BREAK1 4'hB
`define TAP_OP_BYPASS 4'hF

// Data register widths
`define TAP_ID_W 32
`define TAP_BS_W_DEF 8
`define TAP_PROG_W_DEF 16
`define TAP_ISC_W_DEF 16
`define TAP_BPC_W_DEF 16

// Identification word; value is arbitrary, bit 0 set as usual for IDs
`define TAP_ID_VALUE_DEF 32'h0000_0001

`endif

// >>> tap_port_pkg.sv
// Types for the test access port: controller states, data register
// selection and the state record of the test clock domain.
// Assumes tap_port_consts.svh is on the include path.
`include "tap_port_consts.svh"

package tap_port_pkg;

	// Sixteen controller states, one-hot
	typedef enum logic [15:0] {
		ST_RESET = 16'h0001,
		ST_IDLE = 16'h0002,
		ST_SEL_DR = 16'h0004,
		ST_CAP_DR = 16'h0008,
		ST_SH_DR = 16'h0010,
		ST_EX1_DR = 16'h0020,
		ST_PAU_DR = 16'h0040,
		ST_EX2_DR = 16'h0080,
		ST_UPD_DR = 16'h0100,
		ST_SEL_IR = 16'h0200,
		ST_CAP_IR = 16'h0400,
		ST_SH_IR = 16'h0800,
		ST_EX1_IR = 16'h1000,
		ST_PAU_IR = 16'h2000,
		ST_EX2_IR = 16'h4000,
		ST_UPD_IR = 16'h8000
	} tap_state_t;

	// Data register placed between the serial pins
	typedef enum logic [5:0] {
		SEL_ID = 6'h01,
		SEL_BYPASS = 6'h02,
		SEL_BOUNDARY = 6'h04,
		SEL_PROG = 6'h08,
		SEL_INTSCAN = 6'h10,
		SEL_BREAK = 6'h20
	} dr_sel_t;

	// Rising-edge state of the test clock domain
	typedef struct packed {
		logic [1:0] rst_sync;
		logic [1:0] ce_sync;
		tap_state_t state;
		logic [`TAP_IR_W-1:0] ir_shift;
		logic [`TAP_IR_W-1:0] ir;
		logic [`TAP_ID_W-1:0] id_shift;
		logic bypass;
		logic upd_tgl;
		logic at_idle;
		logic at_reset;
	} tck_rise_t;

	// Falling-edge state driving the serial output pin
	typedef struct packed {
		logic tdo;
		logic oe;
	} tck_fall_t;

endpackage

// >>> scan_ctrl_if.sv
// Control bundle from the port controller to each scan data register.
// Assumes all members but tdi, which follows the pin, change on the rising test clock edge.
`timescale 1ns/1ps

interface scan_ctrl_if (
	input wire logic tck
);
	logic rst;
	logic run;
	logic capture;
	logic shift;
	logic update;
	logic tdi;

	modport tap (input tck, output rst, run, capture, shift, update, tdi);
	modport chain (input tck, rst, run, capture, shift, update, tdi);
endinterface

// >>> scan_data_reg.sv
// One scan data register: capture, shift and latched parallel output.
// Assumes control from scan_ctrl_if on the test clock; parallel inputs
// are asynchronous levels and are synchronised here.
`timescale 1ns/1ps

module scan_data_reg #(
	parameter int W = 8
) (
	scan_ctrl_if.chain bus,
	input wire logic i_sel,
	input wire logic [W-1:0] i_cap,
	output logic o_sout,
	output logic [W-1:0] o_par
);
	typedef struct packed {
		logic [W-1:0] sync1;
		logic [W-1:0] sync2;
		logic [W-1:0] sync3;
		logic [W-1:0] stab;
		logic [W-1:0] sh;
		logic [W-1:0] par;
	} chain_state_t;

	chain_state_t q;
	chain_state_t d;

	if (W < 1) begin : g_bad_width
		$error("scan_data_reg width must be at least one");
	end

	// Capture, shift toward bit 0, update only when selected
	always_comb begin
		d = q;
		if (bus.rst) begin
			d = '0;
		end else if (bus.run) begin
			d.sync1 = i_cap;
			d.sync2 = q.sync1;
			d.sync3 = q.sync2;
			// A bit counts once the second and third stages agree
			d.stab = (q.sync2 & q.sync3) | ((q.sync2 ^ q.sync3) & q.stab);
			if (i_sel && bus.capture) begin
				d.sh = q.stab;
			end
			if (i_sel && bus.shift) begin
				d.sh = W'({bus.tdi, q.sh} >> 1);
			end
			if (i_sel && bus.update) begin
				d.par = q.sh;
			end
		end
	end

	// Register the record
	always_ff @(posedge bus.tck) begin
		q <= d;
	end

	assign o_sout = q.sh[0];
	assign o_par = q.par;
endmodule

// >>> tap_controller_port_properties.sv
// Checker for the test access port, watching the top-level ports only.
// Assumes TDO is read at rising TCK and both sides are reset by i_srst.
`timescale 1ns/1ps
`include "tap_port_consts.svh"

module tap_controller_port_properties #(
	parameter logic [`TAP_ID_W-1:0] ID_VALUE = `TAP_ID_VALUE_DEF
) (
	input wire logic i_clk,
	input wire logic i_srst,
	input wire logic i_test_port_enable_fuse,
	input wire logic i_test_port_disable_bit,
	input wire logic i_tck,
	input wire logic i_tms,
	input wire logic o_tdo,
	input wire logic o_tdo_oe,
	input wire logic o_pullup_en,
	input wire logic o_gpio_mode,
	input wire logic [`TAP_IR_W-1:0] o_instr,
	input wire logic o_update_stb,
	input wire logic o_run_idle,
	input wire logic o_tap_reset
);
	// Port held off, so the test clock side ignores TMS
	logic held;
	assign held = i_srst || !i_test_port_enable_fuse || i_test_port_disable_bit;

	// Five TMS-high edges then one low: Run-Test/Idle
	sequence seq_reset;
		i_tms [*5] ##1 !i_tms;
	endsequence
	// Idle to Shift-IR
	sequence seq_shir;
		i_tms [*2] ##1 !i_tms [*2];
	endsequence
	// Idle to Shift-DR
	sequence seq_shdr;
		i_tms ##1 !i_tms [*2];
	endsequence

	AST_TLR_FIVE: assert property (
		@(posedge i_tck) disable iff (held) i_tms [*5] |=> !o_tdo_oe)
		else $error("output driven after five TMS-high edges");
	AST_IR_CAP_LSB: assert property (
		@(posedge i_tck) disable iff (held)
		seq_reset ##1 seq_shir |=> o_tdo_oe && o_tdo)
		else $error("first instruction capture bit wrong");
	AST_IR_CAP_BIT1: assert property (
		@(posedge i_tck) disable iff (held)
		seq_reset ##1 seq_shir ##1 !i_tms |=> o_tdo_oe && !o_tdo)
		else $error("second instruction capture bit wrong");
	AST_IR_EXIT_FLOAT: assert property (
		@(posedge i_tck) disable iff (held)
		seq_reset ##1 seq_shir ##1 !i_tms [*3] ##1 i_tms |=> !o_tdo_oe)
		else $error("output still driven after leaving Shift-IR");
	AST_ID_FIRST_BIT: assert property (
		@(posedge i_tck) disable iff (held)
		seq_reset ##1 seq_shdr |=> o_tdo_oe && o_tdo == ID_VALUE[0])
		else $error("first identification bit wrong");
	AST_GPIO_FUSE: assert property (
		@(posedge i_clk) disable iff (i_srst)
		!i_test_port_enable_fuse [*3] |-> ##[0:4] o_gpio_mode)
		else $error("pins not ordinary with fuse clear");
	AST_PULLUP_ON: assert property (
		@(posedge i_clk) disable iff (i_srst)
		(i_test_port_enable_fuse && !i_test_port_disable_bit) [*3]
		|-> ##[0:4] o_pullup_en && !o_gpio_mode)
		else $error("open port without pull-ups");
	AST_IDLE_NOT_RESET: assert property (
		@(posedge i_clk) disable iff (i_srst) !(o_run_idle && o_tap_reset))
		else $error("idle and reset flags both high");
	AST_STB_PULSE: assert property (
		@(posedge i_clk) disable iff (i_srst) o_update_stb |=> !o_update_stb)
		else $error("update strobe longer than one cycle");
	AST_INSTR_WITH_STB: assert property (
		@(posedge i_clk) disable iff (i_srst)
		!$stable(o_instr) |-> o_update_stb || $past(o_update_stb))
		else $error("instruction changed without update strobe");
endmodule

bind tap_controller_port tap_controller_port_properties #(
	.ID_VALUE(ID_VALUE)) tap_controller_port_properties_i (
	.i_clk(i_clk), .i_srst(i_srst),
	.i_test_port_enable_fuse(i_test_port_enable_fuse),
	.i_test_port_disable_bit(i_test_port_disable_bit),
	.i_tck(i_tck), .i_tms(i_tms), .o_tdo(o_tdo), .o_tdo_oe(o_tdo_oe),
	.o_pullup_en(o_pullup_en), .o_gpio_mode(o_gpio_mode),
	.o_instr(o_instr), .o_update_stb(o_update_stb),
	.o_run_idle(o_run_idle), .o_tap_reset(o_tap_reset));

// >>> jtag_host_model.sv
// Behavioural external test controller driving TCK, TMS and TDI.
// Assumes TDO reaches it through the board pull-up; TCK idles low.
`timescale 1ns/1ps

module jtag_host_model (
	output logic tck,
	output logic tms,
	output logic tdi,
	input wire logic tdo_w
);
	// Clock stands still outside frames
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b1;
	end

	// One 30 ns period: lines set while low, TDO sampled at the rise
	task automatic step(input logic m, input logic d, output logic o);
		tms = m;
		tdi = d;
		#15;
		o = tdo_w;
		tck = 1'b1;
		#15;
		tck = 1'b0;
	endtask

	// TMS pattern applied LSB first
	task automatic nav(input logic [7:0] pat, input int n);
		logic o;
		for (int i = 0; i < n; i++) begin
			step(pat[i], 1'b0, o);
		end
	endtask

	// Shift LSB first, TMS raised with the last bit
	task automatic shift(input logic [63:0] din, input int n,
		output logic [63:0] dout);
		dout = '0;
		for (int i = 0; i < n; i++) begin
			step(i == n - 1, din[i], dout[i]);
		end
	endtask

	// Instruction scan from Idle back to Idle
	task automatic ir_scan(input logic [3:0] op, output logic [3:0] cap);
		logic [63:0] q;
		nav(8'h03, 4);
		shift({60'h0, op}, 4, q);
		cap = q[3:0];
		nav(8'h01, 2);
	endtask

	// Data scan from Idle back to Idle
	task automatic dr_scan(input logic [63:0] din, input int n,
		output logic [63:0] dout);
		nav(8'h01, 3);
		shift(din, n, dout);
		nav(8'h01, 2);
	endtask
endmodule

// >>> tap_controller_port_tb_top.sv
// Self-checking bench for the test access port with a host model.
// Assumes the host model clocks TCK only while it scans.
`timescale 1ns/1ps
`include "tap_port_consts.svh"

module tap_controller_port_tb_top;
	localparam int CW = 8;
	localparam logic [31:0] ID_VAL = 32'h2468_ACE1; // Arbitrary value
	localparam logic [31:0] CAP = 32'hC3A5_5A3C;
	logic clk, srst, ce, fuse, dis, tck, tms, tdi, tdo_w, o_tdo, o_tdo_oe;
	logic o_pullup_en, o_gpio_mode, o_update_stb, o_run_idle, o_tap_reset;
	logic [3:0] o_instr;
	logic [4*CW-1:0] o_chain_upd;
	int error_cnt = 0;
	int check_count = 0;
	int stb_cnt = 0;
	int n0;

	// Board pull-up on the serial output
	assign tdo_w = o_tdo_oe ? o_tdo : 1'b1;

	tap_controller_port #(.BS_W(CW), .PROG_W(CW), .ISC_W(CW), .BPC_W(CW),
		.ID_VALUE(ID_VAL)) tap_controller_port_i (
		.i_clk(clk), .i_srst(srst), .i_ce(ce),
		.i_test_port_enable_fuse(fuse), .i_test_port_disable_bit(dis),
		.i_tck(tck), .i_tms(tms), .i_tdi(tdi), .i_chain_cap(CAP),
		.o_tdo(o_tdo), .o_tdo_oe(o_tdo_oe), .o_pullup_en(o_pullup_en),
		.o_gpio_mode(o_gpio_mode), .o_instr(o_instr),
		.o_chain_upd(o_chain_upd), .o_update_stb(o_update_stb),
		.o_run_idle(o_run_idle), .o_tap_reset(o_tap_reset));
	jtag_host_model jtag_host_model_i (.tck(tck), .tms(tms), .tdi(tdi),
		.tdo_w(tdo_w));

	// 200 MHz system clock
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// Count update strobes
	always @(posedge clk) begin
		if (o_update_stb === 1'b1) stb_cnt++;
	end

	task automatic check(input string what, input logic [63:0] seen,
		input logic [63:0] exp);
		check_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask

	task automatic finish_test();
		if (error_cnt == 0 && check_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// Bounded wait for a new strobe, then let synchronisers settle
	task automatic wait_stb(input int n);
		for (int i = 0; i < 60 && stb_cnt == n; i++) begin
			@(posedge clk);
		end
		repeat (3) @(posedge clk);
		#1;
	endtask

	task automatic t_load(input logic [3:0] op);
		logic [3:0] cap;
		n0 = stb_cnt;
		jtag_host_model_i.ir_scan(op, cap);
		check("ir capture", cap, `TAP_IR_CAPTURE);
		wait_stb(n0);
		check("instruction", o_instr, op);
		check("run idle", o_run_idle, 1'b1);
	endtask

	task automatic t_after_reset();
		jtag_host_model_i.nav(8'h1F, 5);
		repeat (6) @(posedge clk);
		#1;
		check("tap reset", o_tap_reset, 1'b1);
		check("instruction", o_instr, `TAP_OP_IDCODE);
		check("chain outputs", o_chain_upd, 64'h0);
		check("pull-ups", o_pullup_en, 1'b1);
		check("gpio mode", o_gpio_mode, 1'b0);
		jtag_host_model_i.nav(8'h00, 1);
	endtask

	task automatic t_id_bypass();
		logic [63:0] q;
		t_load(`TAP_OP_IDCODE);
		jtag_host_model_i.dr_scan(64'h0, 32, q);
		check("id word", q[31:0], ID_VAL);
		t_load(`TAP_OP_BYPASS);
		jtag_host_model_i.dr_scan(64'hB6, 8, q);
		check("bypass out", q[7:0], 8'h6C);
	endtask

	task automatic t_chains();
		logic [3:0] ops [7];
		int sl [7];
		logic [63:0] q;
		logic [7:0] din;
		logic [4*CW-1:0] exp;
		ops = '{`TAP_OP_SAMPLE, `TAP_OP_EXTEST, `TAP_OP_PROG,
			`TAP_OP_ISCAN0, `TAP_OP_ISCAN1, `TAP_OP_BREAK0, `TAP_OP_BREAK1};
		sl = '{0, 0, 1, 2, 2, 3, 3};
		exp = '0;
		for (int k = 0; k < 7; k++) begin
			din = 8'h91 ^ 8'(k * 37);
			t_load(ops[k]);
			n0 = stb_cnt;
			jtag_host_model_i.dr_scan({56'h0, din}, CW, q);
			check("chain capture", q[7:0], CAP[sl[k]*CW +: CW]);
			if (k > 0) begin
				exp[sl[k]*CW +: CW] = din;
				wait_stb(n0);
				check("chain update", o_chain_upd, exp);
			end
		end
	endtask

	task automatic t_tms_reset();
		logic [63:0] q;
		t_load(`TAP_OP_BYPASS);
		jtag_host_model_i.nav(8'h01, 3);
		jtag_host_model_i.nav(8'h1F, 5);
		repeat (12) @(posedge clk);
		#1;
		check("tap reset", o_tap_reset, 1'b1);
		check("instruction", o_instr, `TAP_OP_IDCODE);
		jtag_host_model_i.nav(8'h00, 1);
		jtag_host_model_i.dr_scan(64'h0, 32, q);
		check("id word", q[31:0], ID_VAL);
	endtask

	task automatic t_disable();
		logic [3:0] cap;
		for (int k = 0; k < 2; k++) begin
			@(posedge clk);
			#1;
			fuse = 1'(k);
			dis = 1'(k);
			repeat (4) @(posedge clk);
			jtag_host_model_i.nav(8'h1F, 5);
			jtag_host_model_i.ir_scan(`TAP_OP_BYPASS, cap);
			repeat (12) @(posedge clk);
			#1;
			check("held capture", cap, 4'hF);
			check("tap reset", o_tap_reset, 1'b1);
			check("instruction", o_instr, `TAP_OP_IDCODE);
			if (k == 0) check("gpio mode", o_gpio_mode, 1'b1);
		end
		@(posedge clk);
		#1;
		fuse = 1'b1;
		dis = 1'b0;
		repeat (6) @(posedge clk);
		#1;
		check("pull-ups", o_pullup_en, 1'b1);
		check("gpio mode", o_gpio_mode, 1'b0);
		jtag_host_model_i.nav(8'h1F, 5);
		jtag_host_model_i.nav(8'h00, 1);
		t_load(`TAP_OP_BYPASS);
	endtask

	// Clock enable low: TMS-high run must leave the controller in Idle
	task automatic t_freeze();
		repeat (6) @(posedge clk);
		#1;
		ce = 1'b0;
		jtag_host_model_i.nav(8'h00, 2);
		jtag_host_model_i.nav(8'h1F, 5);
		@(posedge clk);
		#1;
		ce = 1'b1;
		jtag_host_model_i.nav(8'h00, 2);
		repeat (6) @(posedge clk);
		#1;
		check("frozen idle", o_run_idle, 1'b1);
		check("frozen reset", o_tap_reset, 1'b0);
	endtask

	// Reset with the test clock running, then the scenarios
	initial begin
		srst = 1'b1;
		ce = 1'b1;
		fuse = 1'b1;
		dis = 1'b0;
		fork
			repeat (12) @(posedge clk);
			jtag_host_model_i.nav(8'h1F, 5);
		join
		@(posedge clk);
		#1;
		srst = 1'b0;
		t_after_reset();
		t_id_bypass();
		t_freeze();
		t_chains();
		t_tms_reset();
		t_disable();
		finish_test();
	end

	// Watchdog well beyond the expected run time
	initial begin
		#60us;
		error_cnt++;
		finish_test();
	end
endmodule
